// [rtl/wlb_pkg.sv]
// shared constants and types of the word logic and bit datapath
package wlb_pkg;

  // ----------------------------------------------------------------
  // opcode field
  // ----------------------------------------------------------------
  localparam int WLB_OP_W = 5;
  localparam logic [4:0] OP_AND16 = 5'h00;
  localparam logic [4:0] OP_AND32 = 5'h01;
  localparam logic [4:0] OP_OR16 = 5'h02;
  localparam logic [4:0] OP_OR32 = 5'h03;
  localparam logic [4:0] OP_XOR16 = 5'h04;
  localparam logic [4:0] OP_XOR32 = 5'h05;
  localparam logic [4:0] OP_XNOR16 = 5'h06;
  localparam logic [4:0] OP_XNOR32 = 5'h07;
  localparam logic [4:0] OP_RCR16 = 5'h08;
  localparam logic [4:0] OP_ROR32 = 5'h09;
  localparam logic [4:0] OP_ROL32 = 5'h0a;
  localparam logic [4:0] OP_SFR16 = 5'h0b;
  localparam logic [4:0] OP_PROBE16 = 5'h0c;
  localparam logic [4:0] OP_PROBE32 = 5'h0d;
  localparam logic [4:0] OP_ONES16 = 5'h0e;
  localparam logic [4:0] OP_ONES32 = 5'h0f;
  localparam logic [4:0] OP_SEARCH = 5'h10;
  localparam logic [4:0] OP_EXPAND = 5'h11;
  localparam logic [4:0] OP_COMPRESS = 5'h12;
  localparam logic [4:0] OP_NSPLIT = 5'h13;
  localparam logic [4:0] OP_NJOIN = 5'h14;
  localparam logic [4:0] OP_W2B = 5'h15;
  localparam logic [4:0] OP_B2W = 5'h16;
  localparam logic [4:0] OP_MAX16 = 5'h17;
  localparam logic [4:0] OP_MAX32 = 5'h18;
  localparam logic [4:0] OP_MIN16 = 5'h19;
  localparam logic [4:0] OP_MIN32 = 5'h1a;
  localparam logic [4:0] OP_BIT_FORCE_ONE = 5'h1b;
  localparam logic [4:0] OP_BIT_FORCE_ZERO = 5'h1c;

  // ----------------------------------------------------------------
  // widths, limits and reset values
  // ----------------------------------------------------------------
  localparam int WLB_CNT_W = 9;
  localparam logic [8:0] WLB_SPLIT_MAX = 9'h004;
  localparam logic [8:0] WLB_CODE_MAX = 9'h008;
  localparam logic WLB_CARRY_RST = 1'b0;
  localparam logic [31:0] WLB_WORD_RST = 32'h0000_0000;

  // sequencing states of the datapath
  typedef enum {ST_IDLE, ST_FETCH, ST_TAKE, ST_STEP, ST_WRITE, ST_DONE} wlb_state_t;

endpackage

// [rtl/wlb_bitunit.sv]
// single-cycle logic, bit probe, bit force and ones-count unit
`timescale 1ns/1ps
`default_nettype none
module wlb_bitunit
  import wlb_pkg::*;
(
  input wire logic [4:0] op_in,
  input wire logic [31:0] a_in,
  input wire logic [31:0] b_in,
  input wire logic [8:0] n_in,
  output logic [31:0] result_out,
  output logic bit_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // ones count over a word; 16-bit callers pass a zero upper half
  function automatic logic [31:0] ones_of(input logic [31:0] w);
    logic [31:0] sum;
    sum = 32'h0;
    for (int i = 0; i < 32; i++) begin
      sum = sum + {31'h0, w[i]};
    end
    return sum;
  endfunction

  // ----------------------------------------------------------------
  // operand views
  // ----------------------------------------------------------------
  wire logic [31:0] lo_a = {16'h0, a_in[15:0]};
  wire logic [31:0] lo_b = {16'h0, b_in[15:0]};
  wire logic [15:0] force_mask = 16'h0001 << n_in[3:0];

  // one result per opcode; the 16-bit forms return a zero upper half
  always_comb begin
    result_out = WLB_WORD_RST;
    bit_out = 1'b0;
    unique case (op_in)
      OP_AND16: result_out = lo_a & lo_b;
      OP_AND32: result_out = a_in & b_in;
      OP_OR16: result_out = lo_a | lo_b;
      OP_OR32: result_out = a_in | b_in;
      OP_XOR16: result_out = lo_a ^ lo_b;
      OP_XOR32: result_out = a_in ^ b_in;
      OP_XNOR16: result_out = {16'h0, ~(a_in[15:0] ^ b_in[15:0])};
      OP_XNOR32: result_out = ~(a_in ^ b_in);
      OP_PROBE16: begin
        bit_out = a_in[b_in[3:0]];
        result_out = {31'h0, a_in[b_in[3:0]]};
      end
      OP_PROBE32: begin
        bit_out = a_in[b_in[4:0]];
        result_out = {31'h0, a_in[b_in[4:0]]};
      end
      OP_ONES16: result_out = ones_of(lo_a);
      OP_ONES32: result_out = ones_of(a_in);
      OP_BIT_FORCE_ONE: result_out = {16'h0, a_in[15:0] | force_mask};
      OP_BIT_FORCE_ZERO: result_out = {16'h0, a_in[15:0] & ~force_mask};
      default: result_out = WLB_WORD_RST;
    endcase
  end

endmodule
`default_nettype wire

// [rtl/wlb_datapath.sv]
// word logic and bit datapath: sequencing of multi-cycle operations
`timescale 1ns/1ps
`default_nettype none
module wlb_datapath
  import wlb_pkg::*;
#(
  parameter int CNT_W = WLB_CNT_W
)(
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic START_IN,
  input wire logic [4:0] OPCODE_IN,
  input wire logic [31:0] SRC_A_IN,
  input wire logic [31:0] SRC_B_IN,
  input wire logic [CNT_W-1:0] COUNT_IN,
  input wire logic [31:0] ELEM_DATA_IN,
  output logic ELEM_RD_OUT,
  output logic [7:0] ELEM_ADDR_OUT,
  output logic RES_WE_OUT,
  output logic [7:0] RES_ADDR_OUT,
  output logic [31:0] RES_DATA_OUT,
  output logic RES_BIT_OUT,
  output logic CARRY_FLAG_OUT,
  output logic BUSY_OUT,
  output logic DONE_OUT
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  // the count must reach 256 to cover all 256 element addresses
  if (CNT_W != WLB_CNT_W) begin : g_bad_cnt
    $error("wlb_datapath: CNT_W must equal 9");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // words spanned by a 2^n-bit field, at least one
  function automatic logic [8:0] field_words(input logic [8:0] n);
    if (n <= 9'h004) begin
      return 9'h001;
    end
    return 9'h001 << (n - 9'h004);
  endfunction

  // position of the highest set bit of a halfword
  function automatic logic [3:0] msb_of(input logic [15:0] w);
    logic [3:0] pos;
    pos = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (w[i]) begin
        pos = 4'(i);
      end
    end
    return pos;
  endfunction

  // one bit step of the rotate and shift family: {carry, word}
  function automatic logic [32:0] step_of(input logic [4:0] op, input logic [31:0] d,
                                          input logic c);
    unique case (op)
      OP_RCR16: return {d[0], 16'h0, c, d[15:1]};
      OP_ROR32: return {d[0], d[0], d[31:1]};
      OP_ROL32: return {d[31], d[30:0], d[31]};
      default: return {d[0], 16'h0, 1'b0, d[15:1]};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  wlb_state_t state;
  logic [8:0] idx;
  logic [31:0] acc;
  logic [15:0] first_hit;
  logic [15:0] hit_count;
  logic carry_flag;
  logic elem_rd;
  logic [7:0] elem_addr;
  logic res_we;
  logic [7:0] res_addr;
  logic [31:0] res_data;
  logic res_bit;
  logic busy;
  logic done;

  // ----------------------------------------------------------------
  // opcode decode
  // ----------------------------------------------------------------
  // operands are read straight from the ports; they stay put until done
  wire logic [4:0] op = OPCODE_IN;
  wire logic [8:0] n = COUNT_IN;
  wire logic is_shift = (op == OP_RCR16) || (op == OP_ROR32) || (op == OP_ROL32) ||
                        (op == OP_SFR16);
  wire logic is_single = (op <= OP_XNOR32) || (op == OP_PROBE16) || (op == OP_PROBE32) ||
                         (op == OP_ONES16) || (op == OP_ONES32) || (op == OP_BIT_FORCE_ONE) ||
                         (op == OP_BIT_FORCE_ZERO);
  wire logic is_probe = (op == OP_PROBE16) || (op == OP_PROBE32);
  wire logic write_only = (op == OP_EXPAND) || (op == OP_NSPLIT);
  wire logic is_max = (op == OP_MAX16) || (op == OP_MAX32);
  wire logic is_wide_cmp = (op == OP_MAX32) || (op == OP_MIN32);
  wire logic [8:0] split_n = (n > WLB_SPLIT_MAX) ? WLB_SPLIT_MAX : n;
  wire logic [8:0] code_n = (n > WLB_CODE_MAX) ? WLB_CODE_MAX : n;

  // number of elements read, and number of final result words
  wire logic [8:0] read_len = (op == OP_COMPRESS) ? field_words(code_n) :
                              (op == OP_NJOIN) ? split_n : n;
  wire logic [8:0] write_len = (op == OP_SEARCH) ? 9'h002 :
                               (op == OP_EXPAND) ? field_words(code_n) :
                               (op == OP_NSPLIT) ? split_n : 9'h001;
  wire logic last_read = (idx + 9'h001) == read_len;
  wire logic last_write = (idx + 9'h001) == write_len;

  // ----------------------------------------------------------------
  // single-cycle unit
  // ----------------------------------------------------------------
  logic [31:0] unit_result;
  logic unit_bit;

  wlb_bitunit u_bitunit (
    .op_in(op),
    .a_in(SRC_A_IN),
    .b_in(SRC_B_IN),
    .n_in(n),
    .result_out(unit_result),
    .bit_out(unit_bit)
  );

  // ----------------------------------------------------------------
  // per-element work on the word fetched last cycle
  // ----------------------------------------------------------------
  wire logic [32:0] stepped = step_of(op, acc, carry_flag);
  wire logic [15:0] key_hit = (ELEM_DATA_IN[15:0] == SRC_A_IN[15:0]) ? 16'h0001 : 16'h0000;
  // a field under 16 bits only owns its low 2^n bits
  wire logic [15:0] field_mask = (code_n >= 9'h004) ? 16'hffff :
                                 16'((17'h00001 << (17'h00001 << code_n[1:0])) - 17'h00001);
  wire logic [15:0] field_word = ELEM_DATA_IN[15:0] & field_mask;
  wire logic [31:0] join_nib = {28'h0, ELEM_DATA_IN[3:0]} << {idx[1:0], 2'b00};
  wire logic [31:0] cmp_new = is_wide_cmp ? ELEM_DATA_IN : {16'h0, ELEM_DATA_IN[15:0]};
  wire logic new_bigger = is_wide_cmp ? ($signed(ELEM_DATA_IN) > $signed(acc)) :
                          ($signed(ELEM_DATA_IN[15:0]) > $signed(acc[15:0]));
  wire logic new_smaller = is_wide_cmp ? ($signed(ELEM_DATA_IN) < $signed(acc)) :
                           ($signed(ELEM_DATA_IN[15:0]) < $signed(acc[15:0]));
  wire logic take_new = (idx == 9'h000) || (is_max ? new_bigger : new_smaller);
  wire logic [7:0] w2b_byte = idx[0] ? ELEM_DATA_IN[15:8] : ELEM_DATA_IN[7:0];

  // next accumulator while taking an element
  logic [31:0] next_acc;
  always_comb begin
    next_acc = acc;
    unique case (op)
      OP_COMPRESS: begin
        // later words hold higher positions, so the last nonzero word wins
        if (field_word != 16'h0000) begin
          next_acc = {24'h0, idx[3:0], msb_of(field_word)};
        end
      end
      OP_NJOIN: next_acc = acc | join_nib;
      OP_B2W: next_acc = {24'h0, ELEM_DATA_IN[7:0]};
      OP_MAX16, OP_MAX32, OP_MIN16, OP_MIN32: begin
        if (take_new) begin
          next_acc = cmp_new;
        end
      end
      default: next_acc = acc;
    endcase
  end

  // ----------------------------------------------------------------
  // final result words
  // ----------------------------------------------------------------
  wire logic [31:0] expand_word = (idx[3:0] == acc[7:4]) ?
                                  {16'h0, 16'h0001 << acc[3:0]} : 32'h0;
  wire logic [31:0] split_word = {28'h0, 4'(SRC_A_IN[15:0] >> {idx[1:0], 2'b00})};
  logic [31:0] final_word;
  always_comb begin
    final_word = acc;
    unique case (op)
      OP_SEARCH: final_word = (idx == 9'h000) ? {16'h0, first_hit} : {16'h0, hit_count};
      OP_EXPAND: final_word = expand_word;
      OP_NSPLIT: final_word = split_word;
      default: final_word = acc;
    endcase
  end

  // element-time writes of the two byte streams
  wire logic b2w_pair_done = idx[0] || last_read;
  wire logic [31:0] b2w_word = idx[0] ? {16'h0, ELEM_DATA_IN[7:0], acc[7:0]} :
                               {24'h0, ELEM_DATA_IN[7:0]};
  wire logic take_we = (op == OP_W2B) || ((op == OP_B2W) && b2w_pair_done);
  wire logic [31:0] take_data = (op == OP_W2B) ? {24'h0, w2b_byte} : b2w_word;
  wire logic [7:0] take_addr = (op == OP_W2B) ? idx[7:0] : 8'(idx >> 1);
  wire logic stream_op = (op == OP_W2B) || (op == OP_B2W);
  // word to bytes reads source word j/2 for destination byte j
  wire logic [7:0] fetch_addr = (op == OP_W2B) ? 8'(idx >> 1) : idx[7:0];

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // one write per cycle keeps the result port a plain strobe; a burst
  // interface would be faster but the sequencer memory is single ported
  always_ff @(posedge REF_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state <= ST_IDLE;
      idx <= 9'h000;
      acc <= WLB_WORD_RST;
      first_hit <= 16'h0000;
      hit_count <= 16'h0000;
      carry_flag <= WLB_CARRY_RST;
      elem_rd <= 1'b0;
      elem_addr <= 8'h00;
      res_we <= 1'b0;
      res_addr <= 8'h00;
      res_data <= WLB_WORD_RST;
      res_bit <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      res_we <= 1'b0;
      elem_rd <= 1'b0;
      done <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          idx <= 9'h000;
          first_hit <= 16'h0000;
          hit_count <= 16'h0000;
          res_bit <= 1'b0;
          if (START_IN) begin
            busy <= 1'b1;
            acc <= WLB_WORD_RST;
            if (is_single) begin
              res_we <= 1'b1;
              res_addr <= 8'h00;
              res_data <= unit_result;
              res_bit <= is_probe && unit_bit;
              state <= ST_DONE;
            end else if (is_shift) begin
              // 16-bit forms drop the upper half so a zero count still writes it clean
              acc <= ((op == OP_ROR32) || (op == OP_ROL32)) ? SRC_A_IN : {16'h0, SRC_A_IN[15:0]};
              state <= (n == 9'h000) ? ST_WRITE : ST_STEP;
            end else if (op == OP_EXPAND) begin
              acc <= {24'h0, SRC_A_IN[7:0] & 8'((9'h001 << code_n) - 9'h001)};
              state <= ST_WRITE;
            end else if (write_only) begin
              state <= (split_n == 9'h000) ? ST_DONE : ST_WRITE;
            end else if (read_len == 9'h000) begin
              state <= ST_DONE;
            end else begin
              state <= ST_FETCH;
            end
          end
        end
        ST_STEP: begin
          acc <= stepped[31:0];
          carry_flag <= stepped[32];
          idx <= idx + 9'h001;
          if ((idx + 9'h001) == n) begin
            idx <= 9'h000;
            state <= ST_WRITE;
          end
        end
        ST_FETCH: begin
          elem_rd <= 1'b1;
          elem_addr <= fetch_addr;
          state <= ST_TAKE;
        end
        ST_TAKE: begin
          acc <= next_acc;
          if ((op == OP_SEARCH) && (key_hit != 16'h0000)) begin
            hit_count <= hit_count + 16'h0001;
            if (hit_count == 16'h0000) begin
              first_hit <= idx[7:0] == 8'h00 ? 16'h0000 : {7'h0, idx};
            end
          end
          if (stream_op) begin
            res_we <= take_we;
            res_addr <= take_addr;
            res_data <= take_data;
          end
          idx <= idx + 9'h001;
          if (last_read) begin
            idx <= 9'h000;
            state <= stream_op ? ST_DONE : ST_WRITE;
          end else begin
            state <= ST_FETCH;
          end
        end
        ST_WRITE: begin
          res_we <= 1'b1;
          res_addr <= idx[7:0];
          res_data <= final_word;
          idx <= idx + 9'h001;
          if (last_write) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          done <= 1'b1;
          busy <= 1'b0;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  assign ELEM_RD_OUT = elem_rd;
  assign ELEM_ADDR_OUT = elem_addr;
  assign RES_WE_OUT = res_we;
  assign RES_ADDR_OUT = res_addr;
  assign RES_DATA_OUT = res_data;
  assign RES_BIT_OUT = res_bit;
  assign CARRY_FLAG_OUT = carry_flag;
  assign BUSY_OUT = busy;
  assign DONE_OUT = done;

endmodule
`default_nettype wire

// [tb/wlb_datapath_asserts.sv]
// port-level assertion checker for the word logic and bit datapath
`timescale 1ns/1ps
`default_nettype none
module wlb_datapath_asserts
  import wlb_pkg::*;
#(
  parameter int CNT_W = WLB_CNT_W
)(
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic START_IN,
  input wire logic [4:0] OPCODE_IN,
  input wire logic [31:0] SRC_A_IN,
  input wire logic [31:0] SRC_B_IN,
  input wire logic [CNT_W-1:0] COUNT_IN,
  input wire logic ELEM_RD_OUT,
  input wire logic RES_WE_OUT,
  input wire logic [31:0] RES_DATA_OUT,
  input wire logic CARRY_FLAG_OUT,
  input wire logic BUSY_OUT,
  input wire logic DONE_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (RST_IN);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic take;
  logic shifty;
  // a start only counts while idle; a start during busy is dropped
  assign take = START_IN && !BUSY_OUT;
  assign shifty = (OPCODE_IN == OP_RCR16) || (OPCODE_IN == OP_ROR32)
    || (OPCODE_IN == OP_ROL32) || (OPCODE_IN == OP_SFR16);
  sequence write_then_done;
    RES_WE_OUT ##1 DONE_OUT;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  busy_on_take_a: assert property (take |=> BUSY_OUT)
    else $error("busy did not rise after start");
  single_latency_a: assert property (take && OPCODE_IN <= OP_XNOR32 |=> write_then_done)
    else $error("logic op write and done out of step");
  and_value_a: assert property (take && OPCODE_IN == OP_AND16 |=>
    RES_DATA_OUT == {16'h0000, $past(SRC_A_IN[15:0]) & $past(SRC_B_IN[15:0])})
    else $error("and16 result wrong");
  xnor_value_a: assert property (take && OPCODE_IN == OP_XNOR32 |=>
    RES_DATA_OUT == ~($past(SRC_A_IN) ^ $past(SRC_B_IN)))
    else $error("xnor32 result wrong");
  ones_value_a: assert property (take && OPCODE_IN == OP_ONES32 |=>
    RES_DATA_OUT == 32'($countones($past(SRC_A_IN))))
    else $error("ones32 count wrong");
  shift_latency_a: assert property (take && OPCODE_IN == OP_SFR16 && COUNT_IN == 4 |->
    ##7 DONE_OUT)
    else $error("shift by four finished at wrong cycle");
  done_pulse_a: assert property (DONE_OUT |=> !DONE_OUT)
    else $error("done longer than one cycle");
  read_spacing_a: assert property (ELEM_RD_OUT |=> !ELEM_RD_OUT)
    else $error("element reads back to back");
  // busy drops on the same edge that raises done, so done marks the fall of busy
  quiet_idle_a: assert property (!BUSY_OUT |-> !RES_WE_OUT && !ELEM_RD_OUT &&
    (DONE_OUT == $past(BUSY_OUT)))
    else $error("activity while idle");
  carry_hold_a: assert property ($changed(CARRY_FLAG_OUT) |-> $past(BUSY_OUT) && shifty)
    else $error("carry moved outside rotate or shift");
endmodule
bind wlb_datapath wlb_datapath_asserts #(.CNT_W(CNT_W)) wlb_datapath_asserts_i (
  .REF_CLK_IN(REF_CLK_IN), .RST_IN(RST_IN), .START_IN(START_IN), .OPCODE_IN(OPCODE_IN),
  .SRC_A_IN(SRC_A_IN), .SRC_B_IN(SRC_B_IN), .COUNT_IN(COUNT_IN), .ELEM_RD_OUT(ELEM_RD_OUT),
  .RES_WE_OUT(RES_WE_OUT), .RES_DATA_OUT(RES_DATA_OUT), .CARRY_FLAG_OUT(CARRY_FLAG_OUT),
  .BUSY_OUT(BUSY_OUT), .DONE_OUT(DONE_OUT));
`default_nettype wire

// [tb/wlb_elem_model.sv]
// element store of the sequencer side, word stands while the read strobe is high
`timescale 1ns/1ps
`default_nettype none
module wlb_elem_model (
  input wire logic clk_in,
  input wire logic rd_in,
  input wire logic [7:0] addr_in,
  output logic [31:0] data_out
);
  logic [31:0] mem [0:255];
  logic [31:0] idle_bus = 32'h5a5a_5a5a;
  // the word stands during the strobe cycle and is taken at the edge ending it;
  // between reads the bus toggles so a late or early sample sees garbage
  always @(posedge clk_in) begin
    idle_bus <= ~idle_bus;
  end
  assign data_out = (rd_in === 1'b1) ? mem[addr_in] : idle_bus;
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking testbench of the word logic and bit datapath
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wlb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic [4:0] op = 5'h00;
  logic [31:0] a = 32'h0000_0000;
  logic [31:0] b = 32'h0000_0000;
  logic [8:0] n = 9'h000;
  wire logic [31:0] edata;
  wire logic rd, we, wbit, carry, busy, done;
  wire logic [7:0] raddr, waddr;
  wire logic [31:0] wdata;
  logic [31:0] res [0:7];
  logic rbit;
  int mismatches = 0;
  int n_tests = 0;
  int cycles = 0;
  int lat;
  // ----------------------------------------------------------------
  // structure
  // ----------------------------------------------------------------
  always #50 clk = ~clk;
  wlb_datapath wlb_datapath_i (.REF_CLK_IN(clk), .RST_IN(rst), .START_IN(start),
    .OPCODE_IN(op), .SRC_A_IN(a), .SRC_B_IN(b), .COUNT_IN(n), .ELEM_DATA_IN(edata),
    .ELEM_RD_OUT(rd), .ELEM_ADDR_OUT(raddr), .RES_WE_OUT(we), .RES_ADDR_OUT(waddr),
    .RES_DATA_OUT(wdata), .RES_BIT_OUT(wbit), .CARRY_FLAG_OUT(carry), .BUSY_OUT(busy),
    .DONE_OUT(done));
  wlb_elem_model elem_i (.clk_in(clk), .rd_in(rd), .addr_in(raddr), .data_out(edata));
  // capture every result write; strobe lasts one cycle so sample each edge
  always @(posedge clk) begin
    if (we === 1'b1) begin
      res[waddr[2:0]] <= wdata;
      rbit <= wbit;
    end
  end
  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      final_report();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("compares %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t word got %h want %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t bit got %b want %b", $time, got, exp);
    end
  endtask
  task automatic load(input logic [31:0] v [4]);
    for (int i = 0; i < 4; i++) elem_i.mem[i] = v[i];
  endtask
  // one operation: pulse start, hold operands until done; lat counts cycles
  task automatic run_op(input logic [4:0] o, input logic [31:0] x, input logic [31:0] y,
                        input logic [8:0] c);
    @(negedge clk);
    for (int i = 0; i < 8; i++) res[i] = 32'hdead_beef;
    @(posedge clk);
    start <= 1'b1;
    op <= o;
    a <= x;
    b <= y;
    n <= c;
    @(posedge clk);
    start <= 1'b0;
    lat = 0;
    do begin
      @(negedge clk);
      lat++;
    end while (done !== 1'b1 && lat < 600);
    if (done !== 1'b1) begin
      mismatches++;
      $display("BAD %0t no done for opcode %h", $time, o);
    end
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_logic();
    logic [31:0] e;
    for (int k = 0; k < 8; k++) begin
      run_op(5'(k), 32'hf0f0_a5c3, 32'h0ff0_3cc3, 9'h000);
      case (k / 2)
        0: e = 32'hf0f0_a5c3 & 32'h0ff0_3cc3;
        1: e = 32'hf0f0_a5c3 | 32'h0ff0_3cc3;
        2: e = 32'hf0f0_a5c3 ^ 32'h0ff0_3cc3;
        default: e = ~(32'hf0f0_a5c3 ^ 32'h0ff0_3cc3);
      endcase
      if (k % 2 == 0) e = e & 32'h0000_ffff;
      check_word(res[0], e);
      check_word(32'(lat), 32'h2);
    end
  endtask
  task automatic t_shift();
    logic [4:0] ops [4] = '{OP_RCR16, OP_ROR32, OP_ROL32, OP_SFR16};
    int cnt [4] = '{3, 1, 5, 4};
    logic [31:0] d;
    logic cy;
    cy = WLB_CARRY_RST;
    for (int k = 0; k < 4; k++) begin
      d = (k == 1 || k == 2) ? 32'h8001_6a53 : 32'h0000_6a53;
      run_op(ops[k], d, 32'h0, 9'(cnt[k]));
      for (int s = 0; s < cnt[k]; s++) begin
        case (k)
          0: {cy, d[15:0]} = {d[0], cy, d[15:1]};
          1: begin cy = d[0]; d = {d[0], d[31:1]}; end
          2: begin cy = d[31]; d = {d[30:0], d[31]}; end
          default: begin cy = d[0]; d = d >> 1; end
        endcase
      end
      check_word(res[0], d);
      check_bit(carry, cy);
      check_word(32'(lat), 32'(cnt[k] + 3));
    end
  endtask
  task automatic t_bits();
    run_op(OP_PROBE16, 32'h0000_0020, 32'd5, 9'h000);
    check_bit(rbit, 1'b1);
    run_op(OP_PROBE32, 32'h7fff_ffff, 32'd31, 9'h000);
    check_bit(rbit, 1'b0);
    run_op(OP_BIT_FORCE_ONE, 32'h0000_1234, 32'h0, 9'd15);
    check_word(res[0], 32'h0000_9234);
    run_op(OP_BIT_FORCE_ZERO, 32'h0000_1234, 32'h0, 9'd4);
    check_word(res[0], 32'h0000_1224);
    run_op(OP_ONES16, 32'hffff_00f7, 32'h0, 9'h000);
    check_word(res[0], 32'd7);
    run_op(OP_ONES32, 32'hffff_00f7, 32'h0, 9'h000);
    check_word(res[0], 32'd23);
  endtask
  task automatic t_search();
    load('{32'h0000_0005, 32'h0000_1234, 32'h0000_0007, 32'habcd_1234});
    run_op(OP_SEARCH, 32'h0000_1234, 32'h0, 9'd4);
    check_word(res[0], 32'd1);
    check_word(res[1], 32'd2);
    check_word(32'(lat), 32'd12);
  endtask
  task automatic t_codes();
    run_op(OP_EXPAND, 32'h0000_0005, 32'h0, 9'd3);
    check_word(res[0], 32'h0000_0020);
    load('{32'h0000_0040, 32'h0, 32'h0, 32'h0});
    run_op(OP_COMPRESS, 32'h0000_0040, 32'h0, 9'd3);
    check_word(res[0], 32'd6);
    run_op(OP_NSPLIT, 32'h0000_4c21, 32'h0, 9'd4);
    for (int j = 0; j < 4; j++) check_word(res[j], (32'h0000_4c21 >> (4 * j)) & 32'hf);
    load('{32'h0000_ff3a, 32'h0000_0005, 32'h0000_1e2f, 32'h0000_0000});
    run_op(OP_NJOIN, 32'h0, 32'h0, 9'd3);
    check_word(res[0], 32'h0000_0f5a);
  endtask
  task automatic t_bytes();
    load('{32'h0000_beef, 32'h0000_1234, 32'h0, 32'h0});
    run_op(OP_W2B, 32'h0, 32'h0, 9'd3);
    check_word(res[0], 32'h0000_00ef);
    check_word(res[1], 32'h0000_00be);
    check_word(res[2], 32'h0000_0034);
    load('{32'h0000_11aa, 32'h0000_22bb, 32'h0000_33cc, 32'h0});
    run_op(OP_B2W, 32'h0, 32'h0, 9'd3);
    check_word(res[0], 32'h0000_bbaa);
    check_word(res[1], 32'h0000_00cc);
  endtask
  task automatic t_extreme();
    load('{32'h0000_0005, 32'h0000_fff0, 32'h0000_7ff0, 32'h0000_8000});
    run_op(OP_MAX16, 32'h0, 32'h0, 9'd4);
    check_word(res[0], 32'h0000_7ff0);
    run_op(OP_MIN16, 32'h0, 32'h0, 9'd4);
    check_word(res[0], 32'h0000_8000);
    load('{32'h0000_0003, 32'hffff_fffe, 32'h8000_0001, 32'h0});
    run_op(OP_MAX32, 32'h0, 32'h0, 9'd3);
    check_word(res[0], 32'h0000_0003);
    run_op(OP_MIN32, 32'h0, 32'h0, 9'd3);
    check_word(res[0], 32'h8000_0001);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_logic();
    t_shift();
    t_bits();
    t_search();
    t_codes();
    t_bytes();
    t_extreme();
    final_report();
  end
endmodule
`default_nettype wire
